// ===== inc/cfgsi_consts.svh
`ifndef CFGSI_CONSTS_SVH
`define CFGSI_CONSTS_SVH
// Timing
`define CFGSI_CLK_HZ 40000000
`define CFGSI_BIT_RATE_HZ 100000
// Quarter bit period in cycles (40 MHz / 100 kHz / 4 = 100)
`define CFGSI_QTR_CYC ((`CFGSI_CLK_HZ / `CFGSI_BIT_RATE_HZ) / 4)
`define CFGSI_QTR_W 8
// Framing
`define CFGSI_ADDR_W 7
`define CFGSI_BYTE_W 8
`define CFGSI_BIT_LAST 3'h7
`define CFGSI_DIR_WRITE 1'b0
`define CFGSI_DIR_READ 1'b1
// Default target address of the configuration memory
`define CFGSI_EEPROM_ADDR 7'h50
`endif

// ===== inc/cfgsi_pkg.sv
package cfgsi_pkg;
	// Bus master state, Gray coded in declaration order
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_START = 4'h1,
		ST_SHIFT = 4'h3,
		ST_ACK = 4'h2,
		ST_STOP = 4'h6,
		ST_RSTART = 4'h7,
		ST_DONE = 4'h5
	} cfgsi_state_t;

	// Byte phase within one load
	typedef enum logic [1:0] {
		PH_ADDR_W = 2'h0,
		PH_REG = 2'h1,
		PH_ADDR_R = 2'h3,
		PH_DATA = 2'h2
	} cfgsi_phase_t;
endpackage

// ===== design/cfgsi_mgmt_detect.sv
`timescale 1ns/10ps
`include "cfgsi_consts.svh"
// Latches the management port strap once after reset release
module cfgsi_mgmt_detect (
	input wire logic sys_clk, // System clock
	input wire logic rst_n, // Synchronised reset
	input wire logic mgmt_serial_data_pin_in, // Management data level
	input wire logic mgmt_clk_pin_in, // Management clock level
	output logic mgmt_port_en, // Slave port present
	output logic mgmt_cfg_wait // Wait for host configuration
);
	typedef struct packed {
		logic done;
		logic en;
	} cfgsi_det_t;

	cfgsi_det_t st_reg;
	cfgsi_det_t st_next;

	// Sample once; pins later carry traffic and must not move the decision
	always_comb begin
		st_next = st_reg;
		if (!st_reg.done) begin
			st_next.done = 1'b1;
			st_next.en = mgmt_serial_data_pin_in & mgmt_clk_pin_in;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign mgmt_port_en = st_reg.en;
	// Host configuration overrides straps while the port is present
	assign mgmt_cfg_wait = st_reg.done & st_reg.en;
endmodule

// ===== design/cfgsi_top.sv
`timescale 1ns/10ps
`include "cfgsi_consts.svh"
// Contract
// - Standard-mode master, 100 kbit/s, 7-bit addressing
// - Master drives clock, START, STOP, direction
// - One dedicated EEPROM, configuration source only
// - Base protocol only, no extensions
// - Write sends address, then register byte
// - Further write bytes stored, address increments
// - Write continues until master STOP
// - Read preceded by address-setting write phase
// - Read bytes come from incrementing location
// - Master ACKs all but last, NACKs last
// - After STOP fresh START, else repeated START
// - Provide SMBus slave port for host (only presence is detected here, no slave port logic)
// - Slave port present when both pins high
// - Data pulled low disables slave port
// - SMBus mode waits host config, ignores straps
module cfgsi_top #(
	parameter int BYTE_CNT_W = 8 // Width of load length
) (
	input wire logic sys_clk, // 40 MHz clock
	input wire logic reset_n, // Async reset, active low
	input wire logic load_start, // Pulse: begin load
	input wire logic load_stop_between, // Use STOP before read phase
	input wire logic [`CFGSI_BYTE_W-1:0] load_reg_addr, // First location
	input wire logic [BYTE_CNT_W-1:0] load_len, // Bytes to read, minus one
	output logic load_busy, // Load running
	output logic load_done, // Pulse: load finished
	output logic load_nak_err, // Target did not acknowledge
	output logic byte_valid, // Pulse: byte_data valid
	output logic [`CFGSI_BYTE_W-1:0] byte_data, // Received byte
	output logic [`CFGSI_BYTE_W-1:0] byte_loc, // Location of byte
	input wire logic scl_in, // Serial clock level
	output logic scl_out, // Always low when driven
	output logic scl_oe, // Pull clock low
	input wire logic sda_in, // Serial data level
	output logic sda_out, // Always low when driven
	output logic sda_oe, // Pull data low
	input wire logic mgmt_serial_data_pin_in, // Management data level
	input wire logic mgmt_clk_pin_in, // Management clock level
	output logic mgmt_port_en, // Slave port present
	output logic mgmt_cfg_wait // Wait for host configuration
);
	typedef struct packed {
		cfgsi_pkg::cfgsi_state_t state;
		cfgsi_pkg::cfgsi_phase_t phase;
		logic [`CFGSI_QTR_W-1:0] qcnt;
		logic [1:0] quarter;
		logic [2:0] bitn;
		logic [`CFGSI_BYTE_W-1:0] shreg;
		logic [`CFGSI_BYTE_W-1:0] loc;
		logic [BYTE_CNT_W-1:0] left;
		logic stop_mid;
		logic scl_low;
		logic sda_low;
		logic busy;
		logic done;
		logic nak;
		logic bvalid;
		logic [`CFGSI_BYTE_W-1:0] bdata;
		logic [`CFGSI_BYTE_W-1:0] bloc;
	} cfgsi_mst_t;

	cfgsi_mst_t st_reg;
	cfgsi_mst_t st_next;
	logic [1:0] rst_sync_reg;
	logic rst_n;
	logic qtick;

	// Two-stage reset release
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// Byte loaded into the shifter for each phase
	function automatic logic [`CFGSI_BYTE_W-1:0] phase_byte(
		input cfgsi_pkg::cfgsi_phase_t ph,
		input logic [`CFGSI_BYTE_W-1:0] reg_addr
	);
		case (ph)
			cfgsi_pkg::PH_ADDR_W: phase_byte = {`CFGSI_EEPROM_ADDR, `CFGSI_DIR_WRITE};
			cfgsi_pkg::PH_REG: phase_byte = reg_addr;
			cfgsi_pkg::PH_ADDR_R: phase_byte = {`CFGSI_EEPROM_ADDR, `CFGSI_DIR_READ};
			default: phase_byte = {`CFGSI_BYTE_W{1'b1}}; // Release data for read
		endcase
	endfunction

	// Quarter-bit tick sets the 100 kbit/s pace
	assign qtick = (st_reg.qcnt == `CFGSI_QTR_W'(`CFGSI_QTR_CYC - 1));

	// Bit engine: each bit is four quarters, clock high in quarters 2-3
	always_comb begin
		st_next = st_reg;
		st_next.done = 1'b0;
		st_next.bvalid = 1'b0;
		st_next.qcnt = qtick ? '0 : st_reg.qcnt + 1'b1;
		if (!st_reg.busy) begin
			st_next.qcnt = '0;
		end
		case (st_reg.state)
			cfgsi_pkg::ST_IDLE: begin
				st_next.scl_low = 1'b0;
				st_next.sda_low = 1'b0;
				if (load_start) begin
					st_next.state = cfgsi_pkg::ST_START;
					st_next.phase = cfgsi_pkg::PH_ADDR_W;
					st_next.loc = load_reg_addr;
					st_next.left = load_len;
					st_next.stop_mid = load_stop_between;
					st_next.busy = 1'b1;
					st_next.nak = 1'b0;
					st_next.quarter = 2'h0;
				end
			end
			cfgsi_pkg::ST_START, cfgsi_pkg::ST_RSTART: begin
				// Data falls while clock is high: START or repeated START
				if (qtick) begin
					st_next.quarter = st_reg.quarter + 1'b1;
					case (st_reg.quarter)
						2'h0: begin
							st_next.sda_low = 1'b0;
						end
						2'h1: begin
							st_next.scl_low = 1'b0;
						end
						2'h2: begin
							st_next.sda_low = 1'b1;
						end
						default: begin
							st_next.scl_low = 1'b1;
							st_next.state = cfgsi_pkg::ST_SHIFT;
							st_next.bitn = 3'h0;
							st_next.shreg = phase_byte(st_reg.phase, st_reg.loc);
						end
					endcase
				end
			end
			cfgsi_pkg::ST_SHIFT, cfgsi_pkg::ST_ACK: begin
				if (qtick) begin
					st_next.quarter = st_reg.quarter + 1'b1;
					case (st_reg.quarter)
						2'h0: begin
							// Master decides who drives data this bit
							if (st_reg.state == cfgsi_pkg::ST_SHIFT) begin
								st_next.sda_low = ~st_reg.shreg[`CFGSI_BYTE_W-1];
							end else if (st_reg.phase == cfgsi_pkg::PH_DATA) begin
								st_next.sda_low = (st_reg.left != '0);
							end else begin
								st_next.sda_low = 1'b0;
							end
						end
						2'h1: begin
							st_next.scl_low = 1'b0;
						end
						2'h2: begin
							// Sample while clock is high
							if (st_reg.state == cfgsi_pkg::ST_SHIFT) begin
								st_next.shreg = {st_reg.shreg[`CFGSI_BYTE_W-2:0], sda_in};
							end else if (st_reg.phase != cfgsi_pkg::PH_DATA && sda_in) begin
								st_next.nak = 1'b1;
							end
						end
						default: begin
							st_next.scl_low = 1'b1;
							if (st_reg.state == cfgsi_pkg::ST_SHIFT) begin
								st_next.bitn = st_reg.bitn + 1'b1;
								if (st_reg.bitn == `CFGSI_BIT_LAST) begin
									st_next.state = cfgsi_pkg::ST_ACK;
								end
							end else if (st_reg.nak) begin
								st_next.state = cfgsi_pkg::ST_STOP;
							end else begin
								st_next.state = cfgsi_pkg::ST_SHIFT;
								st_next.bitn = 3'h0;
								case (st_reg.phase)
									cfgsi_pkg::PH_ADDR_W: begin
										st_next.phase = cfgsi_pkg::PH_REG;
										st_next.shreg = st_reg.loc;
									end
									cfgsi_pkg::PH_REG: begin
										// Address set: switch to read phase
										st_next.phase = cfgsi_pkg::PH_ADDR_R;
										st_next.state = st_reg.stop_mid ?
											cfgsi_pkg::ST_STOP : cfgsi_pkg::ST_RSTART;
									end
									cfgsi_pkg::PH_ADDR_R: begin
										st_next.phase = cfgsi_pkg::PH_DATA;
										st_next.shreg = phase_byte(cfgsi_pkg::PH_DATA, st_reg.loc);
									end
									default: begin
										st_next.bvalid = 1'b1;
										st_next.bdata = st_reg.shreg;
										st_next.bloc = st_reg.loc;
										st_next.loc = st_reg.loc + 1'b1;
										st_next.left = st_reg.left - 1'b1;
										st_next.shreg = phase_byte(cfgsi_pkg::PH_DATA, st_reg.loc);
										if (st_reg.left == '0) begin
											st_next.state = cfgsi_pkg::ST_STOP;
										end
									end
								endcase
							end
						end
					endcase
				end
			end
			cfgsi_pkg::ST_STOP: begin
				// Data rises while clock is high: STOP
				if (qtick) begin
					st_next.quarter = st_reg.quarter + 1'b1;
					case (st_reg.quarter)
						2'h0: begin
							st_next.sda_low = 1'b1;
						end
						2'h1: begin
							st_next.scl_low = 1'b0;
						end
						2'h2: begin
							st_next.sda_low = 1'b0;
						end
						default: begin
							// Mid-load STOP goes back for a fresh START
							if (st_reg.phase == cfgsi_pkg::PH_ADDR_R && !st_reg.nak) begin
								st_next.state = cfgsi_pkg::ST_START;
							end else begin
								st_next.state = cfgsi_pkg::ST_DONE;
							end
						end
					endcase
				end
			end
			cfgsi_pkg::ST_DONE: begin
				st_next.busy = 1'b0;
				st_next.done = 1'b1;
				st_next.state = cfgsi_pkg::ST_IDLE;
			end
			default: begin
				st_next.state = cfgsi_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// Open-drain pins: only ever pull low, single target, no arbitration
	assign scl_out = 1'b0;
	assign scl_oe = st_reg.scl_low;
	assign sda_out = 1'b0;
	assign sda_oe = st_reg.sda_low;
	assign load_busy = st_reg.busy;
	assign load_done = st_reg.done;
	assign load_nak_err = st_reg.nak;
	assign byte_valid = st_reg.bvalid;
	assign byte_data = st_reg.bdata;
	assign byte_loc = st_reg.bloc;

	// Management port presence detect
	cfgsi_mgmt_detect u_detect (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.mgmt_serial_data_pin_in(mgmt_serial_data_pin_in),
		.mgmt_clk_pin_in(mgmt_clk_pin_in),
		.mgmt_port_en(mgmt_port_en),
		.mgmt_cfg_wait(mgmt_cfg_wait)
	);
endmodule

// ===== verification/cfgsi_top_monitor.sv
`timescale 1ns/10ps
module cfgsi_top_monitor #(
	parameter int BYTE_CNT_W = 8 // Length width
) (
	input wire logic sys_clk, // Clock
	input wire logic reset_n, // Reset
	input wire logic load_start, // Start
	input wire logic [7:0] load_reg_addr, // First location
	input wire logic [BYTE_CNT_W-1:0] load_len, // Length
	input wire logic load_busy, // Busy
	input wire logic load_done, // Done
	input wire logic load_nak_err, // Nack
	input wire logic byte_valid, // Strobe
	input wire logic [7:0] byte_loc, // Location
	input wire logic scl_out, // Clock level
	input wire logic scl_oe, // Clock pull
	input wire logic sda_out, // Data level
	input wire logic sda_oe, // Data pull
	input wire logic mgmt_port_en, // Port present
	input wire logic mgmt_cfg_wait // Host wait
);
	logic [7:0] loc_reg;
	logic [BYTE_CNT_W:0] cnt_reg;
	logic [BYTE_CNT_W-1:0] len_reg;
	// Expected location and byte count of the running load
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			loc_reg <= 8'h00;
			cnt_reg <= '0;
			len_reg <= '0;
		end else if (load_start && !load_busy && !load_done) begin
			loc_reg <= load_reg_addr;
			cnt_reg <= '0;
			len_reg <= load_len;
		end else if (byte_valid) begin
			loc_reg <= loc_reg + 8'h01;
			cnt_reg <= cnt_reg + 1'b1;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// Every low phase of the clock lasts half a bit
	sequence scl_low_half;
		##[195:205] $fell(scl_oe);
	endsequence
	a_pins_low_only: assert property (!scl_out && !sda_out)
		else $error("pin driven high");
	a_idle_released: assert property (!load_busy |-> !scl_oe && !sda_oe)
		else $error("bus held while idle");
	a_start_busy: assert property (load_start && !load_busy && !load_done |=> load_busy)
		else $error("start not taken");
	a_start_hold: assert property ($rose(sda_oe) && !scl_oe |-> ##[95:105] $rose(scl_oe))
		else $error("start condition timing");
	a_scl_rate: assert property ($rose(scl_oe) |-> scl_low_half)
		else $error("clock low phase length");
	a_loc_tracks: assert property (byte_valid |-> byte_loc == loc_reg)
		else $error("byte location wrong");
	a_len_count: assert property (load_done && !load_nak_err |-> cnt_reg == len_reg + 1)
		else $error("byte count wrong");
	a_nak_no_data: assert property (load_done && load_nak_err |-> cnt_reg == 0)
		else $error("data after refusal");
	a_done_pulse: assert property (load_done |=> !load_done && !load_busy)
		else $error("done not a pulse");
	a_strap_hold: assert property (mgmt_port_en |=> mgmt_port_en && mgmt_cfg_wait)
		else $error("strap result lost");
endmodule

bind cfgsi_top cfgsi_top_monitor #(.BYTE_CNT_W(BYTE_CNT_W)) cfgsi_top_monitor_i (
	.sys_clk, .reset_n, .load_start, .load_reg_addr, .load_len, .load_busy, .load_done,
	.load_nak_err, .byte_valid, .byte_loc, .scl_out, .scl_oe, .sda_out, .sda_oe,
	.mgmt_port_en, .mgmt_cfg_wait);

// ===== verification/cfgsi_eeprom_model.sv
`timescale 1ns/10ps
// Configuration memory; released data floats high by pull-up
module cfgsi_eeprom_model (
	input wire logic scl, // Bus clock
	input wire logic sda, // Bus data
	input wire logic nak_all, // Refuse headers
	output logic sda_pull // Pull data low
);
	logic [3:0] bc = 4'h0;
	logic [7:0] sh, loc, tx;
	logic sel = 1'b0;
	logic rd = 1'b0;
	logic hdr = 1'b0;
	logic regb = 1'b0;
	initial sda_pull = 1'b0;
	// Start or repeated start restarts framing, keeps location
	// The clock fall that ends a start is not a bit: count from one below zero
	always @(negedge sda) if (scl === 1'b1) begin
		bc = 4'hF;
		hdr = 1'b1;
		sel = 1'b0;
	end
	// Stop deselects
	always @(posedge sda) if (scl === 1'b1) sel = 1'b0;
	always @(posedge scl) begin
		if (bc < 8) sh = {sh[6:0], sda};
		else if (sel && rd && sda) sel = 1'b0;
	end
	// Changes only while clock low
	always @(negedge scl) begin
		if (bc == 8) begin
			bc = 4'h0;
			sda_pull = 1'b0;
			if (sel && rd) begin
				tx = loc ^ 8'hA5;
				loc = loc + 8'h01;
			end
		end else begin
			bc = bc + 4'h1;
			if (bc == 8 && hdr) begin
				hdr = 1'b0;
				sel = sh[7:1] == 7'h50 && !nak_all;
				rd = sh[0];
				regb = !sh[0];
				sda_pull = sel;
			end else if (bc == 8 && sel && !rd) begin
				loc = regb ? sh : loc + 8'h01;
				regb = 1'b0;
				sda_pull = 1'b1;
			end else if (bc == 8) sda_pull = 1'b0;
		end
		if (sel && rd && bc < 8) sda_pull = !tx[3'h7 - bc[2:0]];
	end
endmodule

// ===== verification/cfgsi_top_bench.sv
`timescale 1ns/10ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin \
	$display("Error %s expected %h seen %h", n, e, a); error_cnt++; end end
module cfgsi_top_bench;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic load_start = 1'b0;
	logic load_stop_between = 1'b0;
	logic [7:0] load_reg_addr = 8'h00;
	logic [7:0] load_len = 8'h00;
	logic mgmt_serial_data_pin_in = 1'b1;
	logic mgmt_clk_pin_in = 1'b1;
	logic nak_all = 1'b0;
	logic load_busy, load_done, load_nak_err, byte_valid, scl_oe, sda_oe, pull;
	logic mgmt_port_en, mgmt_cfg_wait;
	logic [7:0] byte_data, byte_loc;
	wire scl = !scl_oe;
	wire sda = !(sda_oe || pull);
	int error_cnt = 0;
	int samples_checked = 0;
	int n_start, n_stop;
	always #12.5 sys_clk = !sys_clk;
	// Bus conditions seen during a load
	always @(negedge sda) if (scl === 1'b1) n_start++;
	always @(posedge sda) if (scl === 1'b1) n_stop++;
	cfgsi_top cfgsi_top_i (.sys_clk, .reset_n, .load_start, .load_stop_between,
		.load_reg_addr, .load_len, .load_busy, .load_done, .load_nak_err, .byte_valid,
		.byte_data, .byte_loc, .scl_in(scl), .scl_out(), .scl_oe, .sda_in(sda),
		.sda_out(), .sda_oe, .mgmt_serial_data_pin_in, .mgmt_clk_pin_in,
		.mgmt_port_en, .mgmt_cfg_wait);
	cfgsi_eeprom_model cfgsi_eeprom_model_i (.scl, .sda, .nak_all, .sda_pull(pull));
	task test_done;
		$display("checked %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task do_reset(input logic d, input logic c);
		reset_n <= 1'b0;
		mgmt_serial_data_pin_in <= d;
		mgmt_clk_pin_in <= c;
		repeat (4) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (6) @(posedge sys_clk);
	endtask
	// Strap levels latched once after reset; no host writes or attach modelled
	task test_strap;
		do_reset(1'b0, 1'b1);
		`CHK("port_en", 1'b0, mgmt_port_en)
		`CHK("cfg_wait", 1'b0, mgmt_cfg_wait)
		do_reset(1'b1, 1'b0);
		`CHK("port_en", 1'b0, mgmt_port_en)
		do_reset(1'b1, 1'b1);
		`CHK("port_en", 1'b1, mgmt_port_en)
		`CHK("cfg_wait", 1'b1, mgmt_cfg_wait)
		mgmt_serial_data_pin_in <= 1'b0;
		repeat (3) @(posedge sys_clk);
		`CHK("port_en", 1'b1, mgmt_port_en)
		mgmt_serial_data_pin_in <= 1'b1;
		$display("strap test done");
	endtask
	// One load, with a second start thrown in while busy
	task run_load(input logic sb, input logic [7:0] a, input logic [7:0] len, input logic nk);
		int i;
		int k;
		nak_all <= nk;
		load_stop_between <= sb;
		load_reg_addr <= a;
		load_len <= len;
		load_start <= 1'b1;
		n_start = 0;
		n_stop = 0;
		@(posedge sys_clk);
		load_start <= 1'b0;
		@(posedge sys_clk);
		load_reg_addr <= 8'h33;
		load_start <= 1'b1;
		@(posedge sys_clk);
		load_start <= 1'b0;
		i = 0;
		k = 0;
		while (load_done !== 1'b1 && k < 30000) begin
			@(negedge sys_clk);
			k++;
			if (byte_valid === 1'b1) begin
				`CHK("byte_data", (a + i[7:0]) ^ 8'hA5, byte_data)
				`CHK("byte_loc", a + i[7:0], byte_loc)
				i++;
			end
		end
		if (k >= 30000) begin
			error_cnt++;
			test_done;
		end
		`CHK("bytes", nk ? 0 : len + 1, i)
		`CHK("nak_err", nk, load_nak_err)
		`CHK("starts", nk ? 1 : 2, n_start)
		`CHK("stops", (!nk && sb) ? 2 : 1, n_stop)
		@(negedge sys_clk);
		`CHK("busy", 1'b0, load_busy)
		@(posedge sys_clk);
		$display("load test done");
	endtask
	initial begin
		test_strap;
		run_load(1'b0, 8'hFF, 8'h01, 1'b0);
		run_load(1'b1, 8'h10, 8'h00, 1'b0);
		run_load(1'b0, 8'h20, 8'h00, 1'b1);
		test_done;
	end
endmodule
